// File: hw/cmd_reg_pkg.sv
// Package with command register layout, reset values and carrier structs
package cmd_reg_pkg;
	// Register offset in configuration space (byte address)
	localparam logic [11:0] CMD_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h006;
	localparam logic [11:0] CMD_DWORD = 12'h004;
	// Command register reset value
	localparam logic [15:0] CMD_RESET = 16'h0000;
	// Command field positions
	localparam int IO_SPACE_BIT = 0;
	localparam int MEM_SPACE_BIT = 1;
	localparam int BUS_MASTER_BIT = 2;
	localparam int SPECIAL_BIT = 3;
	localparam int WRITE_INV_BIT = 4;
	localparam int PALETTE_BIT = 5;
	localparam int POISON_PERMIT_BIT = 6;
	localparam int STEPPING_BIT = 7;
	localparam int ERR_MSG_BIT = 8;
	localparam int BACK_TO_BACK_BIT = 9;
	localparam int INT_DISABLE_BIT = 10;
	// Mask of bits that hold state
	localparam logic [15:0] CMD_RW_MASK = 16'h0546;
	// Status flag positions (within status halfword)
	localparam int DATA_POISON_BIT = 8;
	localparam int SIGNALLED_ERR_BIT = 14;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// Configuration request from the link layer
	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] addr;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} cfg_req_s;

	// Configuration read answer
	typedef struct packed {
		logic valid;
		logic [31:0] rdata;
	} cfg_rsp_s;

	// Link events that touch the status flags
	typedef struct packed {
		logic poison_cpl_rx;
		logic poison_wr_rx;
		logic err_msg_req;
	} link_evt_s;
endpackage : cmd_reg_pkg

// File: hw/status_flags.sv
// Sticky status flags gated by the command permissions
`timescale 1ns/1ps
module status_flags (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Permissions
	input wire logic poison_flag_permit,
	input wire logic error_message_permit,
	// Events
	input wire cmd_reg_pkg::link_evt_s evt,
	input wire logic err_msg_sent,
	// Clear request from a status write, one bit per flag
	input wire logic clr_poison,
	input wire logic clr_error,
	// Flags
	output logic data_poison_flag,
	output logic signalled_error_flag
);
	logic poison_ff;
	logic error_ff;
	logic nxt_poison;
	logic nxt_error;

	// Set wins over a clear in the same cycle so no event is lost
	always_comb begin
		nxt_poison = poison_ff;
		nxt_error = error_ff;
		if (clr_poison) begin
			nxt_poison = 1'b0;
		end
		if (clr_error) begin
			nxt_error = 1'b0;
		end
		if (poison_flag_permit && (evt.poison_cpl_rx || evt.poison_wr_rx)) begin
			nxt_poison = 1'b1;
		end
		if (error_message_permit && err_msg_sent) begin
			nxt_error = 1'b1;
		end
	end

	// Flag registers
	always_ff @(posedge clk) begin
		if (rst) begin
			poison_ff <= 1'b0;
			error_ff <= 1'b0;
		end else begin
			poison_ff <= nxt_poison;
			error_ff <= nxt_error;
		end
	end

	assign data_poison_flag = poison_ff;
	assign signalled_error_flag = error_ff;
endmodule : status_flags

// File: hw/pcie_command_register.sv
// Command register of the configuration header with its link gating
`timescale 1ns/1ps
module pcie_command_register (
	// Clock and reset (link or global reset already combined)
	input wire logic clk,
	input wire logic rst,
	// Configuration access port
	input wire cmd_reg_pkg::cfg_req_s cfg_req,
	output cmd_reg_pkg::cfg_rsp_s cfg_rsp,
	// Downstream request classification
	input wire logic rx_req_valid,
	input wire logic rx_req_is_mem,
	input wire logic rx_req_is_io,
	output logic rx_req_accept,
	output logic rx_req_unsupported,
	// Upstream request initiation
	input wire logic tx_req_want,
	output logic tx_req_allow,
	// Error message path
	input wire logic err_msg_want,
	output logic err_msg_send,
	// Link events
	input wire cmd_reg_pkg::link_evt_s evt,
	// Legacy interrupt
	input wire logic intx_request,
	output logic intx_assert,
	// Command bits for the rest of the function
	output logic bus_master_permit,
	output logic mem_space_permit,
	output logic io_space_permit,
	output logic poison_flag_permit,
	output logic error_message_permit,
	output logic int_disable,
	output logic back_to_back_permit,
	output logic stepping_permit,
	output logic palette_snoop_permit,
	output logic write_invalidate_permit,
	// Status flags
	output logic data_poison_flag,
	output logic signalled_error_flag
);
	logic [15:0] cmd_ff;
	logic [15:0] nxt_cmd;
	cmd_reg_pkg::cfg_rsp_s rsp_ff;
	cmd_reg_pkg::cfg_rsp_s nxt_rsp;
	logic hit;
	logic [15:0] wr_half;
	logic [15:0] wr_mask;
	logic [15:0] status_view;
	logic clr_poison;
	logic clr_error;

	// Expand the low two byte enables into a bit mask
	function automatic logic [15:0] lane_mask(input logic [1:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction : lane_mask

	assign hit = cfg_req.valid && (cfg_req.addr[11:2] == cmd_reg_pkg::CMD_DWORD[11:2]);
	assign wr_half = cfg_req.wdata[15:0];
	assign wr_mask = lane_mask(cfg_req.byte_en[1:0]);

	// Only stateful bits take a write; the rest stay zero
	always_comb begin
		nxt_cmd = cmd_ff;
		if (hit && cfg_req.write) begin
			nxt_cmd = (cmd_ff & ~(wr_mask & cmd_reg_pkg::CMD_RW_MASK))
				| (wr_half & wr_mask & cmd_reg_pkg::CMD_RW_MASK);
		end
		nxt_cmd = nxt_cmd & cmd_reg_pkg::CMD_RW_MASK;
	end

	// Command register; and the other writable bits reset to zero
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_ff <= cmd_reg_pkg::CMD_RESET;
		end else begin
			cmd_ff <= nxt_cmd;
		end
	end

	// Status flags write-one-to-clear on the upper lanes of the dword
	assign clr_poison = hit && cfg_req.write && cfg_req.byte_en[3]
		&& cfg_req.wdata[16 + cmd_reg_pkg::DATA_POISON_BIT];
	assign clr_error = hit && cfg_req.write && cfg_req.byte_en[3]
		&& cfg_req.wdata[16 + cmd_reg_pkg::SIGNALLED_ERR_BIT];

	// Sticky flags with their permission gating
	status_flags status_flags_inst (
		.clk(clk),
		.rst(rst),
		.poison_flag_permit(poison_flag_permit),
		.error_message_permit(error_message_permit),
		.evt(evt),
		.err_msg_sent(err_msg_send),
		.clr_poison(clr_poison),
		.clr_error(clr_error),
		.data_poison_flag(data_poison_flag),
		.signalled_error_flag(signalled_error_flag)
	);

	// Status halfword as far as this block owns it
	always_comb begin
		status_view = cmd_reg_pkg::STATUS_RESET;
		status_view[cmd_reg_pkg::DATA_POISON_BIT] = data_poison_flag;
		status_view[cmd_reg_pkg::SIGNALLED_ERR_BIT] = signalled_error_flag;
	end

	// Read answer one cycle after the request; other dwords are not ours
	always_comb begin
		nxt_rsp.valid = hit && !cfg_req.write;
		nxt_rsp.rdata = 32'h00000000;
		if (hit && !cfg_req.write) begin
			nxt_rsp.rdata = {status_view, cmd_ff};
		end
	end

	// Read data is registered
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff <= nxt_rsp;
		end
	end

	assign cfg_rsp = rsp_ff;

	// Field views
	assign io_space_permit = cmd_ff[cmd_reg_pkg::IO_SPACE_BIT];
	assign mem_space_permit = cmd_ff[cmd_reg_pkg::MEM_SPACE_BIT];
	assign bus_master_permit = cmd_ff[cmd_reg_pkg::BUS_MASTER_BIT];
	assign poison_flag_permit = cmd_ff[cmd_reg_pkg::POISON_PERMIT_BIT];
	assign error_message_permit = cmd_ff[cmd_reg_pkg::ERR_MSG_BIT];
	assign int_disable = cmd_ff[cmd_reg_pkg::INT_DISABLE_BIT];
	assign back_to_back_permit = cmd_ff[cmd_reg_pkg::BACK_TO_BACK_BIT];
	assign stepping_permit = cmd_ff[cmd_reg_pkg::STEPPING_BIT];
	assign palette_snoop_permit = cmd_ff[cmd_reg_pkg::PALETTE_BIT];
	assign write_invalidate_permit = cmd_ff[cmd_reg_pkg::WRITE_INV_BIT];

	// io always unsupported
	// Requests that are neither memory nor I/O pass through unhindered
	always_comb begin
		rx_req_accept = 1'b0;
		rx_req_unsupported = 1'b0;
		if (rx_req_valid) begin
			if (rx_req_is_io) begin
				rx_req_unsupported = 1'b1;
			end else if (rx_req_is_mem) begin
				rx_req_accept = mem_space_permit;
				rx_req_unsupported = !mem_space_permit;
			end else begin
				rx_req_accept = 1'b1;
			end
		end
	end

	assign tx_req_allow = tx_req_want && bus_master_permit;

	assign err_msg_send = err_msg_want && error_message_permit;

	assign intx_assert = intx_request && !int_disable;
endmodule : pcie_command_register

// File: sim/cmd_reg_checker.sv
// Port assertions for the command register
`timescale 1ns/1ps
module cmd_reg_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration port
	input wire cmd_reg_pkg::cfg_req_s cfg_req,
	input wire cmd_reg_pkg::cfg_rsp_s cfg_rsp,
	// Link gating
	input wire logic rx_req_valid,
	input wire logic rx_req_is_mem,
	input wire logic rx_req_is_io,
	input wire logic rx_req_unsupported,
	input wire logic tx_req_allow,
	input wire logic err_msg_send,
	// Command bits and flags
	input wire logic bus_master_permit,
	input wire logic mem_space_permit,
	input wire logic io_space_permit,
	input wire logic back_to_back_permit,
	input wire logic stepping_permit,
	input wire logic poison_flag_permit,
	input wire logic error_message_permit,
	input wire logic data_poison_flag,
	input wire logic signalled_error_flag
);
	// One clock domain, so one default for all
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_RD_ZERO: assert property (
		cfg_rsp.valid |-> (cfg_rsp.rdata[15:0] & 16'hfab9) == 16'h0000)
		else $error("hardwired command bit read as one");
	AST_HARDWIRED: assert property (
		!(back_to_back_permit | stepping_permit | io_space_permit))
		else $error("hardwired permit output high");
	AST_READ_ANSWER: assert property (
		cfg_req.valid && !cfg_req.write && cfg_req.addr[11:2] == 10'h001 |=> cfg_rsp.valid)
		else $error("read not answered one cycle later");
	AST_WRITE_TAKES: assert property (
		cfg_req.valid && cfg_req.write && cfg_req.byte_en[0] && cfg_req.addr[11:2] == 10'h001
		|=> mem_space_permit == $past(cfg_req.wdata[1]))
		else $error("memory permit missed a write");
	AST_NO_MASTER: assert property (tx_req_allow |-> bus_master_permit)
		else $error("request allowed without master permit");
	AST_MEM_UR: assert property (
		rx_req_valid && rx_req_is_mem && !mem_space_permit |-> rx_req_unsupported)
		else $error("memory request not refused");
	AST_IO_UR: assert property (rx_req_valid && rx_req_is_io |-> rx_req_unsupported)
		else $error("io request not refused");
	AST_POISON: assert property (
		$rose(data_poison_flag) |-> $past(poison_flag_permit))
		else $error("poison flag set while not permitted");
	AST_SIGNALLED_ERROR_FLAG: assert property (
		$rose(signalled_error_flag) |-> $past(err_msg_send) && $past(error_message_permit))
		else $error("error flag set without permitted message");
	AST_ERR_GATE: assert property (err_msg_send |-> error_message_permit)
		else $error("error message sent while not permitted");
endmodule : cmd_reg_checker

bind pcie_command_register cmd_reg_checker cmd_reg_checker_inst (.clk, .rst, .cfg_req, .cfg_rsp,
	.rx_req_valid, .rx_req_is_mem, .rx_req_is_io, .rx_req_unsupported, .tx_req_allow,
	.err_msg_send, .bus_master_permit, .mem_space_permit, .io_space_permit,
	.back_to_back_permit, .stepping_permit, .poison_flag_permit, .error_message_permit,
	.data_poison_flag, .signalled_error_flag);

// File: sim/root_port_model.sv
// Root port model issuing configuration requests
`timescale 1ns/1ps
module root_port_model (
	// Clock
	input wire logic clk,
	// Request toward the register
	output cmd_reg_pkg::cfg_req_s cfg_req
);
	// Idle at time zero
	initial cfg_req = '0;
	// One access per call; released data is inverted so stale values never match
	task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		@(posedge clk);
		cfg_req <= '{valid: 1'b1, write: wr, addr: addr, byte_en: 4'hf, wdata: data};
		@(posedge clk);
		cfg_req <= '{valid: 1'b0, write: ~wr, addr: ~addr, byte_en: 4'h0, wdata: ~data};
	endtask : xfer
endmodule : root_port_model

// File: sim/pcie_command_register_tb.sv
// Self-checking bench for the command register
`timescale 1ns/1ps
`define CHK(a,b) begin checks++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pcie_command_register_tb;
	logic clk = 0, rst = 1, rx_req_valid = 1, rx_req_is_mem = 1, rx_req_is_io = 0;
	logic tx_req_want = 1, err_msg_want = 0, intx_request = 1;
	logic rx_req_unsupported, tx_req_allow, err_msg_send, intx_assert, io_space_permit;
	logic [15:0] lfsr = 16'd18309;
	logic [31:0] e;
	logic [31:0] exp_q[$];
	int fails = 0, checks = 0;
	cmd_reg_pkg::cfg_req_s cfg_req;
	cmd_reg_pkg::cfg_rsp_s cfg_rsp;
	cmd_reg_pkg::link_evt_s evt = '0;
	// 10 MHz clock
	always #50 clk = ~clk;
	root_port_model root_port_model_inst (.clk(clk), .cfg_req(cfg_req));
	pcie_command_register pcie_command_register_inst (.clk(clk), .rst(rst), .cfg_req(cfg_req),
		.cfg_rsp(cfg_rsp), .rx_req_valid(rx_req_valid), .rx_req_is_mem(rx_req_is_mem),
		.rx_req_is_io(rx_req_is_io), .rx_req_accept(), .rx_req_unsupported(rx_req_unsupported),
		.tx_req_want(tx_req_want), .tx_req_allow(tx_req_allow), .err_msg_want(err_msg_want),
		.err_msg_send(err_msg_send), .evt(evt), .intx_request(intx_request),
		.intx_assert(intx_assert), .bus_master_permit(), .mem_space_permit(),
		.io_space_permit(io_space_permit), .poison_flag_permit(), .error_message_permit(),
		.int_disable(), .back_to_back_permit(), .stepping_permit(), .palette_snoop_permit(),
		.write_invalidate_permit(), .data_poison_flag(), .signalled_error_flag());
	function automatic logic [15:0] step(input logic [15:0] l);
		return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
	endfunction : step
	task automatic rd(input logic [31:0] x);
		exp_q.push_back(x);
		root_port_model_inst.xfer(1'b0, cmd_reg_pkg::CMD_OFFSET, 32'h0);
	endtask : rd
	// Link gates are combinational, so look at mid-cycle with the message request raised
	task automatic gates(input logic [15:0] c);
		@(posedge clk) err_msg_want <= 1'b1;
		@(negedge clk);
		`CHK(tx_req_allow, c[2])
		`CHK(rx_req_unsupported, !c[1])
		`CHK(err_msg_send, c[8])
		`CHK(intx_assert, !c[10])
		`CHK(io_space_permit, 1'b0)
		@(posedge clk) err_msg_want <= 1'b0;
		@(posedge clk) evt <= 3'b110;
		@(posedge clk) evt <= 3'b000;
	endtask : gates
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done
	// Every answer takes the oldest expectation; an answer nobody asked for is a mismatch
	always @(posedge clk) begin
		if (cfg_rsp.valid === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_0000;
			`CHK(cfg_rsp.rdata, e)
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(32'h0);
		gates(16'h0000);
		rd(32'h0);
		$display("reset and closed gates done");
		// Random writes keep the error permit low so the status flags stay put
		repeat (6) begin
			lfsr = step(lfsr);
			root_port_model_inst.xfer(1'b1, cmd_reg_pkg::CMD_OFFSET, {16'h0, lfsr & 16'hfeff});
			rd({16'h0, lfsr & 16'hfeff & cmd_reg_pkg::CMD_RW_MASK});
		end
		$display("random writes done");
		root_port_model_inst.xfer(1'b1, cmd_reg_pkg::CMD_OFFSET, 32'h0000_ffff);
		gates(16'h0546);
		rd(32'h4100_0546);
		@(posedge clk) rx_req_is_io <= 1'b1;
		@(negedge clk) `CHK(rx_req_unsupported, 1'b1)
		root_port_model_inst.xfer(1'b1, cmd_reg_pkg::CMD_OFFSET, 32'h4100_0546);
		rd(32'h0000_0546);
		root_port_model_inst.xfer(1'b0, 12'h008, 32'h0);
		repeat (3) @(posedge clk);
		$display("open gates and unmapped read done");
		test_done();
	end
	// Watchdog far beyond the fifty or so cycles the tests need
	initial begin
		#200000;
		fails++;
		test_done();
	end
endmodule : pcie_command_register_tb
